// ---- tb/mme_host_model.sv ----
// Behavioural host at the far end of the single-wire serial link.
`timescale 1ns/1ps
`default_nettype none
module mme_host_model (
  input wire logic clk, // Bit time reference.
  input wire logic line, // Resolved line level.
  output logic pull_low // High while pulling low.
);
  localparam int BIT_CLKS = 278;
  // The host only ever pulls low; released, the pullup wins.
  initial
    pull_low = 1'b0;
  // Low start, data LSB first, stop; a low stop bit after an all-zero byte makes a break.
  task automatic send_frame(input logic [7:0] dat, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, dat, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk);
      #1 pull_low = ~frame[k];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    #1 pull_low = 1'b0;
    @(posedge clk);
    #1;
  endtask : send_frame
  // Sampled mid-bit; own frames show here too, so call it only after a send.
  task automatic recv_frame(input int wait_max, output logic [7:0] dat,
    output logic stop_bit, output int waited);
    dat = 8'h00;
    stop_bit = 1'b1;
    waited = 0;
    while (line === 1'b1 && waited < wait_max)
    begin
      @(posedge clk);
      #1 waited++;
    end
    if (waited < wait_max)
    begin
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int k = 0; k < 9; k++)
      begin
        repeat (BIT_CLKS) @(posedge clk);
        if (k < 8)
          dat[k] = line;
        else
          stop_bit = line;
      end
      repeat (BIT_CLKS) @(posedge clk);
    end
    #1;
  endtask : recv_frame
endmodule : mme_host_model
`default_nettype wire

// ---- tb/mme_top_checker.sv ----
// Port assertions for the monitor entry and serial link block.
`timescale 1ns/1ps
`default_nettype none
module mme_top_checker (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Reset.
  input wire logic reset_pin_in, // Reset pin.
  input wire logic irq_test_voltage, // Irq voltage.
  input wire logic rst_test_voltage, // Reset voltage.
  input wire logic monitor_serial_pin_in, // Line.
  input wire logic monitor_serial_pin_out, // Drive.
  input wire logic monitor_serial_pin_oe_b, // Enable.
  input wire logic rx_valid, // Byte valid.
  input wire logic sec_done, // Security done.
  input wire logic cmd_ready, // Commands open.
  input wire logic monitor_mode, // Monitor.
  input wire logic forced_mode, // Forced.
  input wire logic [1:0] bus_div_sel, // Divider.
  input wire logic osc_bypass, // Bypass.
  input wire logic watchdog_timer_disable, // Watchdog off.
  input wire logic [15:0] reset_vec_addr, // Reset vector.
  input wire logic [15:0] swi_vec_addr // Swi vector.
);
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  logic [15:0] high_r;
  logic [15:0] high_nxt;
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Run lengths of drive and idle; the idle count saturates so it never wraps.
  assign low_nxt = monitor_serial_pin_oe_b ? 16'h0000 : low_r + 16'h0001;
  assign high_nxt = monitor_serial_pin_in ? high_r + {15'h0000, ~&high_r} : 16'h0000;
  // Run length registers.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_r <= 16'h0000;
      high_r <= 16'h0000;
    end
    else
    begin
      low_r <= low_nxt;
      high_r <= high_nxt;
    end
  end
  sequence s_pins_quiet;
    $stable(reset_pin_in) [*8];
  endsequence
  sequence s_no_voltage;
    (monitor_mode && !forced_mode && !irq_test_voltage && !rst_test_voltage) [*3];
  endsequence
  sequence s_drive_start;
    $fell(monitor_serial_pin_oe_b) && cmd_ready;
  endsequence
  AST_PULL_ONLY: assert property (monitor_serial_pin_out == 1'b0
    && (monitor_mode || monitor_serial_pin_oe_b)) else $error("serial pin drive wrong");
  AST_DIV_BYPASS: assert property ($stable({forced_mode, osc_bypass, bus_div_sel})
    |-> (bus_div_sel == 2'd1) == osc_bypass) else $error("divider and bypass disagree");
  AST_FORCED_DIV: assert property ($stable(forced_mode) && forced_mode
    |-> bus_div_sel == 2'd3 && !osc_bypass) else $error("forced divider wrong");
  AST_WDOG_FORCED: assert property ($stable(forced_mode) && forced_mode
    |-> watchdog_timer_disable) else $error("forced watchdog running");
  AST_WDOG_OFF: assert property (s_no_voltage |-> !watchdog_timer_disable)
    else $error("watchdog held off without voltage");
  AST_VEC_MAP: assert property ($stable(monitor_mode) |-> {reset_vec_addr, swi_vec_addr}
    == (monitor_mode ? 32'hfefefefc : 32'hfffefffc)) else $error("vector map wrong");
  AST_MODE_HOLD: assert property (s_pins_quiet |-> $stable({monitor_mode, forced_mode,
    bus_div_sel, osc_bypass})) else $error("mode changed without reset");
  AST_SEC_FIRST: assert property (!sec_done |-> !cmd_ready && !rx_valid)
    else $error("command path open early");
  AST_BIT_TIME: assert property ($rose(monitor_serial_pin_oe_b)
    |-> low_r % 16'd278 == 16'd0 && low_r <= 16'd2780) else $error("drive run length wrong");
  AST_ECHO_GAP: assert property (s_drive_start |-> high_r >= 16'd278)
    else $error("drive started without idle");
endmodule : mme_top_checker
bind mme_top mme_top_checker chk (.*);
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the monitor entry and serial link block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("unexpected at %0t: %0h not %0h", $time, (g), (e)); \
    end \
  end
module tb;
  logic clk, rst_b, reset_pin_in, irq_test_voltage, rst_test_voltage, rx_ready, host_pull, ce;
  logic clock_divider_select_pin, mode_select_pin_zero, mode_select_pin_one, serial_select_pin;
  logic [7:0] rst_vec_hi, rst_vec_lo, rx_data, d, a, b;
  logic monitor_serial_pin_out, monitor_serial_pin_oe_b, rx_valid, sec_done, cmd_ready;
  logic monitor_mode, forced_mode, osc_bypass, watchdog_timer_disable, extra_reset, stop, line;
  logic [1:0] bus_div_sel;
  logic [15:0] reset_vec_addr, swi_vec_addr;
  logic [4:0] e;
  logic [2:0] c;
  int err_count, comparisons, w, i, x;
  mme_top dut (.*, .ce(ce), .monitor_serial_pin_in(line));
  mme_host_model host (.clk(clk), .line(line), .pull_low(host_pull));
  // Wired line: either party pulls low, the pullup holds it high otherwise.
  assign line = (monitor_serial_pin_oe_b | monitor_serial_pin_out) & ~host_pull;
  // Free-running bus clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Expected {monitor, forced, divider, bypass} for one set of entry levels.
  function automatic logic [4:0] exp_entry(input logic tv, input logic dv, input logic bl);
    if (tv)
      return dv ? 5'h16 : 5'h13;
    else if (bl)
      return 5'h1e;
    return 5'h06;
  endfunction : exp_entry
  // Power-on style reset, entry levels, then the reset pin rises.
  task automatic enter(input logic tv, input logic dv, input logic bl);
    rst_b = 1'b0;
    reset_pin_in = 1'b0;
    irq_test_voltage = tv;
    rst_test_voltage = 1'b0;
    clock_divider_select_pin = dv;
    mode_select_pin_zero = 1'b1;
    mode_select_pin_one = 1'b0;
    serial_select_pin = 1'b0;
    rst_vec_hi = bl ? 8'hff : 8'($urandom % 255);
    rst_vec_lo = bl ? 8'hff : 8'($urandom);
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk);
    #1 reset_pin_in = 1'b1;
    x = 0;
    repeat (80)
    begin
      @(posedge clk);
      #1 x += int'(extra_reset);
    end
  endtask : enter
  task automatic test_done;
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Hang guard, well beyond the longest expected run.
  initial
  begin
    #(4 * 90000);
    err_count++;
    test_done();
  end
  // Main sequence.
  initial
  begin
    err_count = 0;
    comparisons = 0;
    void'($urandom(96971));
    rx_ready = 1'b0;
    ce = 1'b1;
    enter(1'b0, 1'b0, 1'b0);
    `CHK({monitor_serial_pin_oe_b, reset_vec_addr, swi_vec_addr}, 33'h1fffefffc)
    // Normal low and high divider, forced with random divider pin, programmed user.
    for (i = 0; i < 4; i++)
    begin
      a = 8'($urandom);
      c = {i < 2, i == 1 || (i == 2 && a[0]), i == 2};
      enter(c[2], c[1], c[0]);
      e = exp_entry(c[2], c[1], c[0]);
      `CHK({monitor_mode, forced_mode, bus_div_sel, osc_bypass}, e)
      `CHK(x, e[3] ? 16 : 0)
      `CHK(reset_vec_addr, e[4] ? 16'hfefe : 16'hfffe)
      `CHK(swi_vec_addr, e[4] ? 16'hfefc : 16'hfffc)
      for (w = 0; w < 4; w++)
      begin
        irq_test_voltage = w[1];
        rst_test_voltage = w[0];
        clock_divider_select_pin = w[0];
        mode_select_pin_one = w[1];
        repeat (8) @(posedge clk);
        #1;
        `CHK(watchdog_timer_disable, e[3] | (e[4] & (w[1] | w[0])))
      end
      `CHK({monitor_mode, forced_mode, bus_div_sel, osc_bypass}, e)
      // A reset pin pulse while frozen must never be seen, so no new latch follows.
      ce = 1'b0;
      reset_pin_in = 1'b0;
      repeat (8) @(posedge clk);
      #1 reset_pin_in = 1'b1;
      repeat (8) @(posedge clk);
      #1 ce = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      `CHK({monitor_mode, forced_mode, bus_div_sel, osc_bypass}, e)
    end
    // Security bytes get no echo; the break follows the last one.
    enter(1'b1, 1'b0, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      `CHK({sec_done, cmd_ready, rx_valid}, 3'h0)
      host.send_frame(8'($urandom), 1'b1);
      host.recv_frame(3500, d, stop, w);
    end
    x = 0;
    while (stop !== 1'b0 && x < 3)
    begin
      host.recv_frame(7000, d, stop, w);
      x++;
    end
    `CHK({d, stop, cmd_ready}, 10'h001)
    // Two bytes while the reader stalls; an all-zero byte sits next to a break.
    a = 8'($urandom);
    b = 8'h00;
    for (i = 0; i < 2; i++)
    begin
      host.send_frame(i ? b : a, 1'b1);
      host.recv_frame(4000, d, stop, w);
      `CHK({d, stop}, {i ? b : a, 1'b1})
      `CHK(w >= 139 && w <= 834, 1'b1)
    end
    for (i = 0; i < 3; i++)
    begin
      `CHK({rx_valid, rx_data}, i < 2 ? {1'b1, i ? b : a} : {1'b0, rx_data})
      @(posedge clk);
      #1 rx_ready = 1'b1;
      @(posedge clk);
      #1 rx_ready = 1'b0;
    end
    host.send_frame(8'h00, 1'b0);
    host.recv_frame(4000, d, stop, w);
    `CHK({d, stop, w >= 139 && w <= 834}, 10'h001)
    test_done();
  end
endmodule : tb
`default_nettype wire

// ---- verilog/mme_buf2.sv ----
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module mme_buf2 (
  input wire logic clk, // Clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic [7:0] in_data, // Data in.
  input wire logic in_valid, // Data in valid.
  output logic in_ready, // Space available.
  output logic [7:0] out_data, // Data out, registered.
  output logic out_valid, // Data out valid.
  input wire logic out_ready // Consumer takes data.
);
  logic [7:0] mem_r [0:1];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // Count tells full from empty honestly.
  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rp_r];
  // Pointers and storage advance only while enabled.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end
    else if (ce)
    begin
      if (push)
        mem_r[wp_r] <= in_data;
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
endmodule : mme_buf2
`default_nettype wire

// ---- verilog/mme_map.svh ----
// Constants for the monitor entry and serial link block.
`ifndef MME_MAP_SVH
`define MME_MAP_SVH
`define MME_BAUD_DIV 16'd278
`define MME_HALF_BIT 16'd139
`define MME_SEC_BYTES 4'd8
`define MME_BRK_BITS 4'd10
`define MME_ECHO_GAP_BITS 4'd2
`define MME_FRAME_BITS 4'd10
`define MME_BLANK_BYTE 8'hff
`define MME_VEC_USER_RST 16'hfffe
`define MME_VEC_MON_RST 16'hfefe
`define MME_VEC_USER_SWI 16'hfffc
`define MME_VEC_MON_SWI 16'hfefc
`define MME_DIV2 2'd1
`define MME_DIV4 2'd3
`define MME_EXTRA_RST_CYC 8'd16
`endif

// ---- verilog/mme_pkg.sv ----
// Types shared by the monitor entry and serial link block.
package mme_pkg;
  typedef enum logic [1:0] {
    MME_MODE_USER = 2'b00,
    MME_MODE_NORMAL = 2'b01,
    MME_MODE_FORCED = 2'b10
  } mme_mode_t;
  typedef enum logic [2:0] {
    MME_ST_SEC = 3'b000,
    MME_ST_BRK = 3'b001,
    MME_ST_RUN = 3'b010,
    MME_ST_GAP = 3'b011,
    MME_ST_ECHO = 3'b100,
    MME_ST_BGAP = 3'b101,
    MME_ST_BECHO = 3'b110
  } mme_link_t;
endpackage : mme_pkg

// ---- verilog/mme_top.sv ----
// Monitor-mode entry latch, clock divide select and single-wire serial link.
// How it works
// - All traffic uses one wired-OR serial pin; we only pull low.
// - Normal entry with divider select low: bus clock is input divided by two.
// - Normal entry with divider select high: bus clock is input divided by four.
// - Divider select low bypasses the oscillator halving only under test voltage.
// - Erased reset vector allows entry without test voltage.
// - Forced entry ignores port B pins; bus clock fixed at divide by four.
// - Blank-vector entry adds one extra reset, 16 cycles long, after power-on.
// - Entry pins latch on reset rising edge; later changes are ignored.
// - Wait for eight security bytes before any command.
// - After security bytes, send a ten-low-bit break.
// - Normal entry: watchdog off while test voltage on either pin.
// - Test voltage on reset pin lets the interrupt pin be released.
// - Forced entry disables the watchdog unconditionally.
// - Monitor mode fetches reset, break and interrupt vectors from monitor page.
// - Programmed reset vector needs test voltage for entry.
// - NRZ mark/space format, identical baud both directions.
// - One bit lasts 278 bus clocks.
// - Host-downloaded RAM code may run; other pins keep normal roles.
// - Every byte received after the break is echoed back on the serial pin while the buffer has room.
// - On break: hold high two bit times, then echo the break.
`timescale 1ns/1ps
`default_nettype none
`include "mme_map.svh"
module mme_top (
  input wire logic clk, // Bus-rate clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes state when low.
  input wire logic reset_pin_in, // Reset pin level after conditioning.
  input wire logic irq_test_voltage, // Test voltage sensed on interrupt pin.
  input wire logic rst_test_voltage, // Test voltage sensed on reset pin.
  input wire logic clock_divider_select_pin, // Divider select pin.
  input wire logic mode_select_pin_zero, // Mode select pin zero.
  input wire logic mode_select_pin_one, // Mode select pin one.
  input wire logic serial_select_pin, // Serial select pin.
  input wire logic [7:0] rst_vec_hi, // Reset vector high byte as stored.
  input wire logic [7:0] rst_vec_lo, // Reset vector low byte as stored.
  input wire logic monitor_serial_pin_in, // Serial pin level.
  output logic monitor_serial_pin_out, // Serial pin drive value, always low.
  output logic monitor_serial_pin_oe_b, // Low while pulling the pin low.
  output logic [7:0] rx_data, // Received byte for the firmware.
  output logic rx_valid, // Received byte valid.
  input wire logic rx_ready, // Firmware takes the received byte.
  output logic sec_done, // Eight security bytes received.
  output logic cmd_ready, // Break sent, commands accepted.
  output logic monitor_mode, // Monitor mode latched.
  output logic forced_mode, // Forced entry latched.
  output logic [1:0] bus_div_sel, // Bus clock divide minus one.
  output logic osc_bypass, // Oscillator halving bypassed.
  output logic watchdog_timer_disable, // Watchdog held off.
  output logic extra_reset, // One extra internal reset request.
  output logic [15:0] reset_vec_addr, // Reset vector fetch address.
  output logic [15:0] swi_vec_addr // Break and interrupt vector address.
);
  mme_pkg::mme_mode_t mode_r, mode_nxt;
  mme_pkg::mme_link_t st_r, st_nxt;
  logic [2:0] rx_sync_r;
  logic [2:0] rp_sync_r;
  logic rx_line_r;
  logic rx_prev_r;
  logic rp_line_r;
  logic rp_prev_r;
  logic extra_done_r;
  logic [7:0] xr_cnt_r;
  logic [15:0] rx_tick_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_busy_r;
  logic rx_zero_r;
  logic [15:0] tx_tick_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_sh_r;
  logic tx_busy_r;
  logic [3:0] cnt_r;
  logic [7:0] echo_r;
  logic pin_oe_b_r;
  logic [1:0] div_r;
  logic byp_r;
  logic wd_r;
  logic [15:0] rv_r;
  logic [15:0] sv_r;
  logic xr_r;
  // Three-stage synchronisers; a change counts once stages two and three agree.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rx_sync_r <= 3'b111;
      rp_sync_r <= 3'b000;
      rx_line_r <= 1'b1;
      rx_prev_r <= 1'b1;
      rp_line_r <= 1'b0;
    end
    else if (ce)
    begin
      rx_sync_r <= {rx_sync_r[1:0], monitor_serial_pin_in};
      rp_sync_r <= {rp_sync_r[1:0], reset_pin_in};
      rx_prev_r <= rx_line_r;
      if (rx_sync_r[1] == rx_sync_r[2])
        rx_line_r <= rx_sync_r[2];
      if (rp_sync_r[1] == rp_sync_r[2])
        rp_line_r <= rp_sync_r[2];
    end
  // Entry decode on the reset pin's rising edge.
  wire rp_rise = rp_line_r && !rp_prev_r;
  wire vec_blank = (rst_vec_hi == `MME_BLANK_BYTE) && (rst_vec_lo == `MME_BLANK_BYTE);
  wire pins_ok = mode_select_pin_zero && !mode_select_pin_one && !serial_select_pin;
  wire normal_ok = irq_test_voltage && pins_ok;
  wire forced_ok = !irq_test_voltage && vec_blank && !serial_select_pin;
  always_comb
  begin
    mode_nxt = mode_r;
    if (rp_rise)
    begin
      if (normal_ok)
        mode_nxt = mme_pkg::MME_MODE_NORMAL;
      else if (forced_ok)
        mode_nxt = mme_pkg::MME_MODE_FORCED;
      else
        mode_nxt = mme_pkg::MME_MODE_USER;
    end
  end
  // The mode register updates only at the latch edge, so later pin changes are ignored.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      mode_r <= mme_pkg::MME_MODE_USER;
      rp_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      mode_r <= mode_nxt;
      rp_prev_r <= rp_line_r;
    end
  // Divider select is captured with the mode; forced entry ignores port B.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      div_r <= `MME_DIV4;
      byp_r <= 1'b0;
    end
    else if (ce && rp_rise)
    begin
      if (normal_ok && !clock_divider_select_pin)
      begin
        div_r <= `MME_DIV2;
        byp_r <= 1'b1;
      end
      else
      begin
        div_r <= `MME_DIV4;
        byp_r <= 1'b0;
      end
    end
  // Extra reset after a blank-vector entry, issued once per power-on.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      extra_done_r <= 1'b0;
      xr_cnt_r <= 8'h00;
      xr_r <= 1'b0;
    end
    else if (ce)
    begin
      if (mode_r == mme_pkg::MME_MODE_FORCED && !extra_done_r && !xr_r)
      begin
        xr_r <= 1'b1;
        xr_cnt_r <= `MME_EXTRA_RST_CYC;
      end
      else if (xr_r)
      begin
        xr_cnt_r <= xr_cnt_r - 8'h01;
        if (xr_cnt_r == 8'h01)
        begin
          xr_r <= 1'b0;
          extra_done_r <= 1'b1;
        end
      end
    end
  // Watchdog gate and vector remap follow the latched mode.
  wire mon = (mode_r != mme_pkg::MME_MODE_USER);
  wire wd_nxt = (mode_r == mme_pkg::MME_MODE_FORCED) ||
    (mode_r == mme_pkg::MME_MODE_NORMAL && (irq_test_voltage || rst_test_voltage));
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wd_r <= 1'b0;
      rv_r <= `MME_VEC_USER_RST;
      sv_r <= `MME_VEC_USER_SWI;
    end
    else if (ce)
    begin
      wd_r <= wd_nxt;
      rv_r <= mon ? `MME_VEC_MON_RST : `MME_VEC_USER_RST;
      sv_r <= mon ? `MME_VEC_MON_SWI : `MME_VEC_USER_SWI;
    end
  // Receiver: NRZ, start bit sampled mid-bit, eight data bits LSB first.
  wire rx_tick = (rx_tick_r == 16'd0);
  wire rx_done = rx_busy_r && rx_tick && (rx_bit_r == 4'd9);
  wire rx_brk = rx_done && rx_zero_r && !rx_line_r;
  wire rx_byte = rx_done && rx_line_r;
  // Only a fresh falling edge while we are silent starts a frame, so our own echo is not taken in.
  wire rx_fall = rx_prev_r && !rx_line_r;
  wire rx_listen = !tx_busy_r && (st_r == mme_pkg::MME_ST_SEC || st_r == mme_pkg::MME_ST_RUN);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rx_busy_r <= 1'b0;
      rx_tick_r <= 16'd0;
      rx_bit_r <= 4'd0;
      rx_sh_r <= 8'h00;
      rx_zero_r <= 1'b0;
    end
    else if (ce)
    begin
      if (!rx_busy_r)
      begin
        if (rx_fall && rx_listen && mon)
        begin
          rx_busy_r <= 1'b1;
          rx_tick_r <= `MME_HALF_BIT;
          rx_bit_r <= 4'd0;
          rx_zero_r <= 1'b1;
        end
      end
      else if (rx_tick)
      begin
        rx_tick_r <= `MME_BAUD_DIV - 16'd1;
        rx_bit_r <= rx_bit_r + 4'd1;
        if (rx_bit_r >= 4'd1 && rx_bit_r <= 4'd8)
        begin
          rx_sh_r <= {rx_line_r, rx_sh_r[7:1]};
          if (rx_line_r)
            rx_zero_r <= 1'b0;
        end
        if (rx_bit_r == 4'd9)
          rx_busy_r <= 1'b0;
      end
      else
        rx_tick_r <= rx_tick_r - 16'd1;
    end
  // Received bytes pass a two-entry buffer; while it is full, a new byte is dropped and gets no echo.
  logic buf_in_ready;
  logic [7:0] buf_data;
  logic buf_valid;
  mme_buf2 u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_data(rx_sh_r),
    .in_valid(rx_byte && cmd_ready),
    .in_ready(buf_in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(rx_ready && rx_valid)
  );
  // Link sequencer: security wait, break, then echo each byte the buffer accepts.
  wire tx_idle = !tx_busy_r;
  wire tx_start = tx_idle && (st_nxt == mme_pkg::MME_ST_BRK || st_nxt == mme_pkg::MME_ST_ECHO
    || st_nxt == mme_pkg::MME_ST_BECHO) && (st_r != st_nxt);
  wire gap_end = tx_tick_r == 16'd0 && cnt_r == 4'd0;
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      mme_pkg::MME_ST_SEC:
        if (rx_byte && cnt_r == `MME_SEC_BYTES - 4'd1)
          st_nxt = mme_pkg::MME_ST_BRK;
      mme_pkg::MME_ST_BRK:
        if (tx_idle && tx_bit_r == 4'd15)
          st_nxt = mme_pkg::MME_ST_RUN;
      mme_pkg::MME_ST_RUN:
        if (rx_brk)
          st_nxt = mme_pkg::MME_ST_BGAP;
        else if (rx_byte && buf_in_ready)
          st_nxt = mme_pkg::MME_ST_GAP;
      mme_pkg::MME_ST_GAP:
        if (gap_end)
          st_nxt = mme_pkg::MME_ST_ECHO;
      mme_pkg::MME_ST_BGAP:
        if (gap_end)
          st_nxt = mme_pkg::MME_ST_BECHO;
      mme_pkg::MME_ST_ECHO,
      mme_pkg::MME_ST_BECHO:
        if (tx_idle && tx_bit_r == 4'd15)
          st_nxt = mme_pkg::MME_ST_RUN;
      default:
        st_nxt = mme_pkg::MME_ST_SEC;
    endcase
  end
  // Sequencer registers; counter holds bytes in security, bit times in gaps.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      st_r <= mme_pkg::MME_ST_SEC;
      cnt_r <= 4'd0;
      echo_r <= 8'h00;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      if (st_r == mme_pkg::MME_ST_SEC && rx_byte)
        cnt_r <= cnt_r + 4'd1;
      else if (st_r == mme_pkg::MME_ST_RUN && st_nxt != st_r)
        cnt_r <= `MME_ECHO_GAP_BITS - 4'd1;
      else if ((st_r == mme_pkg::MME_ST_GAP || st_r == mme_pkg::MME_ST_BGAP)
        && tx_tick_r == 16'd0 && cnt_r != 4'd0)
        cnt_r <= cnt_r - 4'd1;
      if (st_r == mme_pkg::MME_ST_RUN && rx_byte)
        echo_r <= rx_sh_r;
    end
  // Transmitter; also times the gap bit periods while idle.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      tx_busy_r <= 1'b0;
      tx_tick_r <= 16'd0;
      tx_bit_r <= 4'd0;
      tx_sh_r <= 10'h3ff;
      pin_oe_b_r <= 1'b1;
    end
    else if (ce)
    begin
      if (tx_start)
      begin
        tx_busy_r <= 1'b1;
        tx_tick_r <= `MME_BAUD_DIV - 16'd1;
        tx_bit_r <= 4'd0;
        // A break is ten zeros; a byte gets start and stop framing.
        tx_sh_r <= (st_nxt == mme_pkg::MME_ST_ECHO) ? {1'b1, echo_r, 1'b0} : 10'h000;
      end
      else if (tx_busy_r || st_r == mme_pkg::MME_ST_GAP || st_r == mme_pkg::MME_ST_BGAP)
      begin
        if (tx_tick_r == 16'd0)
        begin
          tx_tick_r <= `MME_BAUD_DIV - 16'd1;
          if (tx_busy_r)
          begin
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            if (tx_bit_r == `MME_FRAME_BITS - 4'd1)
            begin
              tx_busy_r <= 1'b0;
              tx_bit_r <= 4'd15;
            end
            else
              tx_bit_r <= tx_bit_r + 4'd1;
          end
        end
        else
          tx_tick_r <= tx_tick_r - 16'd1;
      end
      else
        tx_bit_r <= 4'd0;
      // Only a low is ever driven; a high is left to the pullup.
      pin_oe_b_r <= !(tx_busy_r && !tx_sh_r[0]);
    end
  // Outputs: registers, decodes of registers and the constant pin drive.
  assign monitor_serial_pin_out = 1'b0;
  assign monitor_serial_pin_oe_b = pin_oe_b_r;
  assign rx_data = buf_data;
  assign rx_valid = buf_valid;
  assign sec_done = (st_r != mme_pkg::MME_ST_SEC);
  assign cmd_ready = (st_r != mme_pkg::MME_ST_SEC) && (st_r != mme_pkg::MME_ST_BRK);
  assign monitor_mode = mon;
  assign forced_mode = (mode_r == mme_pkg::MME_MODE_FORCED);
  assign bus_div_sel = div_r;
  assign osc_bypass = byp_r;
  assign watchdog_timer_disable = wd_r;
  assign extra_reset = xr_r;
  assign reset_vec_addr = rv_r;
  assign swi_vec_addr = sv_r;
endmodule : mme_top
`default_nettype wire
